// ### shared/vec_cfg.svh
// constants of the vacuum ejector controller
`ifndef VEC_CFG_SVH
`define VEC_CFG_SVH
// timing
`define VEC_CLK_MHZ 125
`define VEC_TICK_NS 1000000
`define VEC_TICK_CYC ((`VEC_TICK_NS * `VEC_CLK_MHZ) / 1000)
`define VEC_HOLD_MS 3000
`define VEC_IDLE_MS 60000
`define VEC_BLINK_BIT 8
// regulation upper limit steps in mbar, index 6 is max
`define VEC_UL0 11'h190
`define VEC_UL1 11'h226
`define VEC_UL2 11'h28A
`define VEC_UL3 11'h2EE
`define VEC_UL4 11'h352
`define VEC_UL5 11'h384
`define VEC_UL_MAX_IDX 4'h6
`define VEC_REG_HYST 11'h032
// part-present limit steps in mbar
`define VEC_PL0 11'h12C
`define VEC_PL1 11'h190
`define VEC_PL2 11'h226
`define VEC_PL3 11'h28A
`define VEC_PL4 11'h2EE
`define VEC_PL5 11'h352
`define VEC_PL6 11'h384
`define VEC_PL_MAX_IDX 4'h6
`define VEC_PART_HYST 11'h00A
// blow-off time steps in ms, index 0 is external
`define VEC_BT1 12'h014
`define VEC_BT2 12'h032
`define VEC_BT3 12'h064
`define VEC_BT4 12'h0FA
`define VEC_BT5 12'h1F4
`define VEC_BT6 12'h2EE
`define VEC_BT7 12'h3E8
`define VEC_BT8 12'h5DC
`define VEC_BT_MAX_IDX 4'h8
// reset values of the settings
`define VEC_UL_RST 4'h3
`define VEC_PL_RST 4'h2
`define VEC_BT_RST 4'h0
`endif

// ### shared/vec_pkg.sv
// types of the vacuum ejector controller
package vec_pkg;
  // keypad mode, one-hot
  typedef enum logic [2:0] {
    VEC_ST_DISP = 3'b001,
    VEC_ST_EDIT = 3'b010,
    VEC_ST_MAN = 3'b100
  } vec_state_t;
  // parameter under edit, one-hot
  typedef enum logic [2:0] {
    VEC_PS_UPPER = 3'b001,
    VEC_PS_PART = 3'b010,
    VEC_PS_BLOW = 3'b100
  } vec_param_t;
endpackage : vec_pkg

// ### hw/vec_ejector_ctrl.sv
// vacuum ejector control: valves, regulation, part-present output, keypad
`include "vec_cfg.svh"
module vec_ejector_ctrl #(
  parameter int TICK_CYC = `VEC_TICK_CYC,
  parameter int HOLD_MS = `VEC_HOLD_MS,
  parameter int IDLE_MS = `VEC_IDLE_MS
) (
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // controller requests and keys (pins)
  input wire logic suction_request_input_in,
  input wire logic blowoff_request_input_in,
  input wire logic key_select_in,
  input wire logic key_down_in,
  input wire logic key_up_in,
  // variant strap and vacuum samples
  input wire logic variant_closed_idle_in,
  input wire logic [10:0] vacuum_mbar_in,
  input wire logic vacuum_valid_in,
  // valves and signal output
  output logic nozzle_valve_out,
  output logic blowoff_valve_out,
  output logic part_present_out,
  // keypad indication
  output vec_pkg::vec_state_t mode_out,
  output logic keypad_locked_out,
  output logic led_upper_out,
  output logic led_part_out,
  output logic led_blow_out,
  output logic [10:0] display_value_out
);
  import vec_pkg::*;

  // step tables
  function automatic logic [10:0] upper_mbar(input logic [3:0] i);
    case (i)
      4'h0: upper_mbar = `VEC_UL0;
      4'h1: upper_mbar = `VEC_UL1;
      4'h2: upper_mbar = `VEC_UL2;
      4'h3: upper_mbar = `VEC_UL3;
      4'h4: upper_mbar = `VEC_UL4;
      4'h5: upper_mbar = `VEC_UL5;
      default: upper_mbar = 11'h7FF; // max step: never reached
    endcase
  endfunction : upper_mbar

  function automatic logic [10:0] part_mbar(input logic [3:0] i);
    case (i)
      4'h0: part_mbar = `VEC_PL0;
      4'h1: part_mbar = `VEC_PL1;
      4'h2: part_mbar = `VEC_PL2;
      4'h3: part_mbar = `VEC_PL3;
      4'h4: part_mbar = `VEC_PL4;
      4'h5: part_mbar = `VEC_PL5;
      default: part_mbar = `VEC_PL6;
    endcase
  endfunction : part_mbar

  function automatic logic [11:0] blow_ms(input logic [3:0] i);
    case (i)
      4'h1: blow_ms = `VEC_BT1;
      4'h2: blow_ms = `VEC_BT2;
      4'h3: blow_ms = `VEC_BT3;
      4'h4: blow_ms = `VEC_BT4;
      4'h5: blow_ms = `VEC_BT5;
      4'h6: blow_ms = `VEC_BT6;
      4'h7: blow_ms = `VEC_BT7;
      4'h8: blow_ms = `VEC_BT8;
      default: blow_ms = 12'h000; // external control
    endcase
  endfunction : blow_ms

  // pin synchroniser: bit0 suction, 1 blow-off, 2 select, 3 down, 4 up
  logic [4:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_f_reg;
  logic [4:0] pin_s1_next, pin_s2_next, pin_s3_next, pin_f_next;

  // three stages; filtered value moves only when stages 2 and 3 agree
  always_comb begin
    pin_s1_next = {key_up_in, key_down_in, key_select_in, blowoff_request_input_in, suction_request_input_in};
    pin_s2_next = pin_s1_reg;
    pin_s3_next = pin_s2_reg;
    pin_f_next = (pin_s2_reg & pin_s3_reg) | (pin_f_reg & (pin_s2_reg | pin_s3_reg));
  end

  // synchroniser registers
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_s1_reg <= 5'h00;
      pin_s2_reg <= 5'h00;
      pin_s3_reg <= 5'h00;
      pin_f_reg <= 5'h00;
    end else if (clk_en_in) begin
      pin_s1_reg <= pin_s1_next;
      pin_s2_reg <= pin_s2_next;
      pin_s3_reg <= pin_s3_next;
      pin_f_reg <= pin_f_next;
    end
  end

  // control state
  vec_state_t state_reg, state_next; // keypad mode
  vec_param_t par_reg, par_next; // parameter under edit
  logic [4:0] prev_reg, prev_next; // filtered pins one cycle ago
  logic [16:0] tick_reg, tick_next; // ms prescaler
  logic [15:0] hold_reg, hold_next; // key hold time in ms
  logic [15:0] idle_reg, idle_next; // menu idle time in ms
  logic [8:0] blink_reg, blink_next; // flash phase
  logic [3:0] ul_reg, ul_next, pl_reg, pl_next, bt_reg, bt_next; // settings
  logic [3:0] val_reg, val_next; // value under edit
  logic dirty_reg, dirty_next; // edit value changed
  logic lock_reg, lock_next;
  logic msuck_reg, msuck_next; // manual suction on
  logic regoff_reg, regoff_next; // nozzle cut by regulation
  logic pp_reg, pp_next; // part present
  logic suct_prev_reg, suct_prev_next;
  logic [11:0] bcnt_reg, bcnt_next; // timed blow-off ms left
  logic [10:0] vac_reg, vac_next; // last sample
  logic noz_reg, noz_next, blow_reg, blow_next;
  logic ledu_reg, ledu_next, ledp_reg, ledp_next, ledb_reg, ledb_next;
  logic [10:0] disp_reg, disp_next;
  // combinational helpers
  logic tick, flash, man, suct, reg_en, chord_rise, req_chg;
  logic [4:0] press;
  logic [10:0] ul_v, pl_v;
  logic [3:0] vmax;

  // next-state of the whole control path
  always_comb begin
    tick = (tick_reg == 17'(TICK_CYC - 1));
    tick_next = tick ? 17'h00000 : tick_reg + 17'h00001;
    blink_next = tick ? blink_reg + 9'h001 : blink_reg;
    flash = blink_reg[`VEC_BLINK_BIT];
    press = pin_f_reg & ~prev_reg;
    req_chg = (pin_f_reg[1:0] != prev_reg[1:0]);
    chord_rise = pin_f_reg[2] & pin_f_reg[3] & ~(prev_reg[2] & prev_reg[3]);
    prev_next = pin_f_reg;
    state_next = state_reg;
    par_next = par_reg;
    hold_next = hold_reg;
    idle_next = idle_reg;
    ul_next = ul_reg;
    pl_next = pl_reg;
    bt_next = bt_reg;
    val_next = val_reg;
    dirty_next = dirty_reg;
    lock_next = lock_reg;
    msuck_next = msuck_reg;
    vmax = (par_reg == VEC_PS_BLOW) ? `VEC_BT_MAX_IDX : `VEC_UL_MAX_IDX;
    case (state_reg)
      VEC_ST_DISP: begin
        // idle: vacuum on display, keys open menu or manual
        idle_next = 16'h0000;
        if (chord_rise) begin
          lock_next = ~lock_reg;
          hold_next = 16'h0000;
        end else if (lock_reg) begin
          hold_next = 16'h0000;
        end else if (press[2]) begin
          state_next = VEC_ST_EDIT;
          par_next = VEC_PS_UPPER;
          val_next = ul_reg;
          dirty_next = 1'b0;
        end else if (pin_f_reg[3] | pin_f_reg[4]) begin
          if (tick) begin
            hold_next = hold_reg + 16'h0001;
          end
          if (hold_reg > 16'(HOLD_MS)) begin
            state_next = VEC_ST_MAN;
            msuck_next = 1'b0;
            hold_next = 16'h0000;
          end
        end else begin
          hold_next = 16'h0000;
        end
      end
      VEC_ST_EDIT: begin
        // menu: step value, select applies or moves to next parameter
        if (|press[4:2]) begin
          idle_next = 16'h0000;
        end else if (tick) begin
          idle_next = idle_reg + 16'h0001;
        end
        if (idle_reg >= 16'(IDLE_MS)) begin
          state_next = VEC_ST_DISP;
        end else if (press[4] && val_reg < vmax) begin
          val_next = val_reg + 4'h1;
          dirty_next = 1'b1;
        end else if (press[3] && val_reg != 4'h0) begin
          val_next = val_reg - 4'h1;
          dirty_next = 1'b1;
        end else if (press[2] && dirty_reg) begin
          state_next = VEC_ST_DISP;
          case (par_reg)
            VEC_PS_UPPER: begin
              if (val_reg == `VEC_UL_MAX_IDX || upper_mbar(val_reg) > part_mbar(pl_reg)) begin
                ul_next = val_reg;
              end
            end
            VEC_PS_PART: begin
              if (ul_reg == `VEC_UL_MAX_IDX || upper_mbar(ul_reg) > part_mbar(val_reg)) begin
                pl_next = val_reg;
              end
            end
            default: bt_next = val_reg;
          endcase
        end else if (press[2]) begin
          case (par_reg)
            VEC_PS_UPPER: begin
              par_next = VEC_PS_PART;
              val_next = pl_reg;
            end
            VEC_PS_PART: begin
              par_next = VEC_PS_BLOW;
              val_next = bt_reg;
            end
            default: state_next = VEC_ST_DISP;
          endcase
        end
      end
      VEC_ST_MAN: begin
        // manual: keys drive valves until select or a request edge
        if (req_chg || press[2]) begin
          state_next = VEC_ST_DISP;
          msuck_next = 1'b0;
        end else if (msuck_reg && (press[3] || press[4])) begin
          msuck_next = 1'b0;
        end else if (press[4]) begin
          msuck_next = 1'b1;
        end
      end
      default: state_next = VEC_ST_DISP;
    endcase

    // suction source and regulation
    man = (state_reg == VEC_ST_MAN);
    suct = man ? msuck_reg : pin_f_reg[0];
    suct_prev_next = suct;
    reg_en = (ul_reg != `VEC_UL_MAX_IDX);
    ul_v = upper_mbar(ul_reg);
    pl_v = part_mbar(pl_reg);
    vac_next = vacuum_valid_in ? vacuum_mbar_in : vac_reg;
    regoff_next = regoff_reg;
    if (!suct || !reg_en) begin
      regoff_next = 1'b0;
    end else if (vacuum_valid_in && vacuum_mbar_in >= ul_v) begin
      regoff_next = 1'b1;
    end else if (vacuum_valid_in && vacuum_mbar_in < ul_v - `VEC_REG_HYST) begin
      regoff_next = 1'b0;
    end
    pp_next = pp_reg;
    if (vacuum_valid_in && vacuum_mbar_in > pl_v) begin
      pp_next = 1'b1;
    end else if (vacuum_valid_in && vacuum_mbar_in < pl_v - `VEC_PART_HYST) begin
      pp_next = 1'b0;
    end

    // timed blow-off counter, loaded as suction ends
    bcnt_next = bcnt_reg;
    if (suct) begin
      bcnt_next = 12'h000;
    end else if (suct_prev_reg && bt_reg != 4'h0) begin
      bcnt_next = blow_ms(bt_reg);
    end else if (tick && bcnt_reg != 12'h000) begin
      bcnt_next = bcnt_reg - 12'h001;
    end

    // valve outputs; open-idle valve is inverted
    noz_next = variant_closed_idle_in ? (suct & ~regoff_reg) : ~(suct & ~regoff_reg);
    if (man) begin
      blow_next = pin_f_reg[3];
    end else if (bt_reg == 4'h0) begin
      blow_next = pin_f_reg[1];
    end else begin
      blow_next = (bcnt_reg != 12'h000);
    end

    // indicators
    ledb_next = 1'b0;
    disp_next = vac_reg;
    case (state_reg)
      VEC_ST_MAN: begin
        ledu_next = pin_f_reg[3] | flash;
        ledp_next = pin_f_reg[3] | flash;
      end
      VEC_ST_EDIT: begin
        ledu_next = (par_reg == VEC_PS_UPPER) & flash;
        ledp_next = (par_reg == VEC_PS_PART) & flash;
        ledb_next = (par_reg == VEC_PS_BLOW) & flash;
        disp_next = {7'h00, val_reg};
      end
      default: begin
        ledu_next = reg_en & (vac_reg >= ul_v);
        ledp_next = pp_reg;
      end
    endcase
  end

  // control registers; power-up lands in automatic display mode
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= VEC_ST_DISP;
      par_reg <= VEC_PS_UPPER;
      prev_reg <= 5'h00;
      tick_reg <= 17'h00000;
      hold_reg <= 16'h0000;
      idle_reg <= 16'h0000;
      blink_reg <= 9'h000;
      ul_reg <= `VEC_UL_RST;
      pl_reg <= `VEC_PL_RST;
      bt_reg <= `VEC_BT_RST;
      val_reg <= 4'h0;
      dirty_reg <= 1'b0;
      lock_reg <= 1'b0;
      msuck_reg <= 1'b0;
      regoff_reg <= 1'b0;
      pp_reg <= 1'b0;
      suct_prev_reg <= 1'b0;
      bcnt_reg <= 12'h000;
      vac_reg <= 11'h000;
      noz_reg <= 1'b0;
      blow_reg <= 1'b0;
      ledu_reg <= 1'b0;
      ledp_reg <= 1'b0;
      ledb_reg <= 1'b0;
      disp_reg <= 11'h000;
    end else if (clk_en_in) begin
      state_reg <= state_next;
      par_reg <= par_next;
      prev_reg <= prev_next;
      tick_reg <= tick_next;
      hold_reg <= hold_next;
      idle_reg <= idle_next;
      blink_reg <= blink_next;
      ul_reg <= ul_next;
      pl_reg <= pl_next;
      bt_reg <= bt_next;
      val_reg <= val_next;
      dirty_reg <= dirty_next;
      lock_reg <= lock_next;
      msuck_reg <= msuck_next;
      regoff_reg <= regoff_next;
      pp_reg <= pp_next;
      suct_prev_reg <= suct_prev_next;
      bcnt_reg <= bcnt_next;
      vac_reg <= vac_next;
      noz_reg <= noz_next;
      blow_reg <= blow_next;
      ledu_reg <= ledu_next;
      ledp_reg <= ledp_next;
      ledb_reg <= ledb_next;
      disp_reg <= disp_next;
    end
  end

  // outputs straight from flip-flops
  assign nozzle_valve_out = noz_reg;
  assign blowoff_valve_out = blow_reg;
  assign part_present_out = pp_reg;
  assign mode_out = state_reg;
  assign keypad_locked_out = lock_reg;
  assign led_upper_out = ledu_reg;
  assign led_part_out = ledp_reg;
  assign led_blow_out = ledb_reg;
  assign display_value_out = disp_reg;

  // checks
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  a_open_idle_nozzle: assert property (clk_en_in && !variant_closed_idle_in && !man && pin_f_reg[0]
    && !regoff_reg |=> !nozzle_valve_out) else $error("open-idle nozzle not off on request");
  a_closed_idle_nozzle: assert property (clk_en_in && variant_closed_idle_in && !man && !pin_f_reg[0]
    |=> !nozzle_valve_out) else $error("closed-idle nozzle on without request");
  a_reg_cutoff: assert property (clk_en_in && suct && reg_en && vacuum_valid_in && vacuum_mbar_in >= ul_v
    |=> regoff_reg) else $error("regulation did not cut nozzle");
  a_reg_resume: assert property (clk_en_in && suct && vacuum_valid_in && vacuum_mbar_in < ul_v - 11'h032
    |=> !regoff_reg) else $error("regulation did not resume");
  a_ext_blow: assert property (clk_en_in && !man && bt_reg == 4'h0
    |=> blowoff_valve_out == $past(pin_f_reg[1])) else $error("external blow-off not followed");
  a_timed_load: assert property (clk_en_in && !suct && suct_prev_reg && bt_reg != 4'h0
    |=> bcnt_reg == blow_ms($past(bt_reg))) else $error("timed blow-off not loaded");
  a_limit_order: assert property (ul_reg == 4'h6 || upper_mbar(ul_reg) > part_mbar(pl_reg))
    else $error("upper limit not above part limit");
  a_max_no_reg: assert property (clk_en_in && ul_reg == 4'h6 |-> ##1 !regoff_reg)
    else $error("regulation active at max step");
  a_part_set: assert property (clk_en_in && vacuum_valid_in && vacuum_mbar_in > pl_v
    |=> part_present_out) else $error("part-present not set");
  a_lock_ignore: assert property (clk_en_in && lock_reg && state_reg == VEC_ST_DISP && !chord_rise
    |=> state_reg == VEC_ST_DISP) else $error("locked keypad left display");
  c_manual: cover property (state_reg == VEC_ST_DISP ##1 state_reg == VEC_ST_MAN);
  c_timed_blow: cover property (bcnt_reg == 12'h001 ##1 bcnt_reg == 12'h000);
  c_apply: cover property (state_reg == VEC_ST_EDIT && dirty_reg ##1 state_reg == VEC_ST_DISP);
  c_regulate: cover property (regoff_reg ##1 !regoff_reg && suct);
endmodule : vec_ejector_ctrl

// ### sim/vec_ctrl_model.sv
// machine controller and vacuum sensor model on the far side of the ejector control
module vec_ctrl_model (
  // clock
  input wire logic clk_sys_in,
  // request lines toward the block
  output logic suction_req_out,
  output logic blowoff_req_out,
  // vacuum sample toward the block
  output logic [10:0] vacuum_mbar_out,
  output logic vacuum_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // lines start idle with no request and no sample
  initial begin
    suction_req_out = 1'b0;
    blowoff_req_out = 1'b0;
    vacuum_mbar_out = 11'h000;
    vacuum_valid_out = 1'b0;
  end
  // request levels change just after a falling edge and then stand
  task automatic set_requests(input logic suction, input logic blowoff);
    @(negedge clk_sys_in);
    suction_req_out = suction;
    blowoff_req_out = blowoff;
  endtask : set_requests
  // one-cycle sample strobe, then a quiet gap; a slow sensor uses a long gap
  task automatic send_sample(input logic [10:0] mbar, input int gap);
    @(negedge clk_sys_in);
    vacuum_mbar_out = mbar;
    vacuum_valid_out = 1'b1;
    @(negedge clk_sys_in);
    vacuum_valid_out = 1'b0;
    // the value is stale once the strobe is gone, so show its inverse
    vacuum_mbar_out = ~mbar;
    repeat (gap) @(negedge clk_sys_in);
  endtask : send_sample
endmodule : vec_ctrl_model

// ### sim/vec_ejector_ctrl_bench.sv
// self-checking bench of the vacuum ejector control
module vec_ejector_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import vec_pkg::*;
  // shortened tick, hold and idle counts keep the run brief
  localparam int TICK = 4;
  localparam int HOLD = 5;
  localparam int IDLE = 20;
  // clock, reset and bench-driven pins
  logic clk_sys_in, rstn_in, closed_idle, clk_en;
  logic key_sel, key_dn, key_up;
  // partner lines and observed outputs
  logic suction_req, blowoff_req, vac_valid;
  logic [10:0] vac_mbar, disp_val;
  logic nozzle, blow, part, locked, led_up, led_pt, led_bl;
  vec_state_t mode;
  // scoreboard counters
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  // design under test, clock enable driven by the bench
  vec_ejector_ctrl #(.TICK_CYC(TICK), .HOLD_MS(HOLD), .IDLE_MS(IDLE)) vec_ejector_ctrl_inst (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .clk_en_in(clk_en),
    .suction_request_input_in(suction_req), .blowoff_request_input_in(blowoff_req),
    .key_select_in(key_sel), .key_down_in(key_dn), .key_up_in(key_up),
    .variant_closed_idle_in(closed_idle), .vacuum_mbar_in(vac_mbar), .vacuum_valid_in(vac_valid),
    .nozzle_valve_out(nozzle), .blowoff_valve_out(blow), .part_present_out(part),
    .mode_out(mode), .keypad_locked_out(locked), .led_upper_out(led_up),
    .led_part_out(led_pt), .led_blow_out(led_bl), .display_value_out(disp_val)
  );
  // far-side controller and sensor
  vec_ctrl_model vec_ctrl_model_inst (
    .clk_sys_in(clk_sys_in), .suction_req_out(suction_req), .blowoff_req_out(blowoff_req),
    .vacuum_mbar_out(vac_mbar), .vacuum_valid_out(vac_valid)
  );
  // 125 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // hang guard: the tests need far fewer cycles than this ceiling
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      $display("unexpected at %0t: run did not finish", $time);
      give_verdict();
    end
  end
  // counts, verdict and end of run
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // single-bit comparison
  task automatic check_bit(input logic act, input logic exp, input string what);
    comparisons++;
    if (act !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s is %b", $time, what, act);
    end
  endtask : check_bit
  // keypad mode comparison
  task automatic check_mode(input vec_state_t exp, input string what);
    comparisons++;
    if (mode !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s, mode %b", $time, what, mode);
    end
  endtask : check_mode
  // display value comparison
  task automatic check_val(input logic [10:0] exp, input string what);
    comparisons++;
    if (disp_val !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s, value %h", $time, what, disp_val);
    end
  endtask : check_val
  // wait whole cycles, ending on a falling edge where inputs may change
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : cyc
  // press keys for a number of cycles, then release and let the filter settle
  task automatic press(input logic s, input logic d, input logic u, input int hold);
    @(negedge clk_sys_in);
    key_sel = s;
    key_dn = d;
    key_up = u;
    cyc(hold);
    key_sel = 1'b0;
    key_dn = 1'b0;
    key_up = 1'b0;
    cyc(8);
  endtask : press
  // state right after reset, open-idle strap
  task automatic test_reset();
    cyc(2);
    check_mode(VEC_ST_DISP, "power-up mode");
    check_bit(nozzle, 1'b1, "open-idle nozzle at rest");
    check_bit(blow, 1'b0, "blow valve at rest");
    check_bit(locked, 1'b0, "lock at rest");
    check_bit(led_bl, 1'b0, "blow led at rest");
    $display("test reset done");
  endtask : test_reset
  // request polarity in both variants, checked well after the input latency
  task automatic test_variants();
    vec_ctrl_model_inst.set_requests(1'b1, 1'b0);
    cyc(8);
    check_bit(nozzle, 1'b0, "open-idle suction");
    vec_ctrl_model_inst.set_requests(1'b0, 1'b0);
    cyc(8);
    check_bit(nozzle, 1'b1, "open-idle release");
    closed_idle = 1'b1;
    cyc(3);
    check_bit(nozzle, 1'b0, "closed-idle at rest");
    vec_ctrl_model_inst.set_requests(1'b1, 1'b0);
    cyc(8);
    check_bit(nozzle, 1'b1, "closed-idle suction");
    vec_ctrl_model_inst.set_requests(1'b0, 1'b0);
    cyc(8);
    $display("test variants done");
  endtask : test_variants
  // regulation at 750 with 50 hysteresis, part limit 550 with 10 hysteresis
  task automatic test_regulation();
    vec_ctrl_model_inst.set_requests(1'b1, 1'b0);
    cyc(8);
    vec_ctrl_model_inst.send_sample(11'h2EE, 2);
    check_bit(nozzle, 1'b0, "cut at upper limit");
    check_bit(part, 1'b1, "part above limit");
    vec_ctrl_model_inst.send_sample(11'h2BD, 2);
    check_bit(nozzle, 1'b0, "still cut at 701");
    vec_ctrl_model_inst.send_sample(11'h2BB, 2);
    check_bit(nozzle, 1'b1, "resumed at 699");
    vec_ctrl_model_inst.send_sample(11'h221, 20);
    check_bit(part, 1'b1, "part held at 545");
    vec_ctrl_model_inst.send_sample(11'h21B, 2);
    check_bit(part, 1'b0, "part released at 539");
    vec_ctrl_model_inst.send_sample(11'h227, 2);
    check_bit(part, 1'b1, "part set at 551");
    check_bit(led_pt, 1'b1, "part led follows part present");
    check_val(11'h227, "vacuum shown in display");
    vec_ctrl_model_inst.set_requests(1'b0, 1'b0);
    cyc(8);
    $display("test regulation done");
  endtask : test_regulation
  // external blow-off follows its request
  task automatic test_ext_blow();
    clk_en = 1'b0;
    vec_ctrl_model_inst.set_requests(1'b0, 1'b1);
    cyc(8);
    check_bit(blow, 1'b0, "blow frozen while disabled");
    clk_en = 1'b1;
    cyc(8);
    check_bit(blow, 1'b1, "external blow on");
    vec_ctrl_model_inst.set_requests(1'b0, 1'b0);
    cyc(8);
    check_bit(blow, 1'b0, "external blow off");
    $display("test external blow done");
  endtask : test_ext_blow
  // manual entry, flashing, suction, regulation, blow and exit by request
  task automatic test_manual();
    int n_up;
    n_up = 0;
    press(1'b0, 1'b1, 1'b0, (HOLD + 5) * TICK);
    check_mode(VEC_ST_MAN, "long down hold");
    check_bit(blow, 1'b0, "blow closed after release");
    repeat (2100) begin
      @(negedge clk_sys_in);
      if (led_up === 1'b1) n_up++;
    end
    check_bit((n_up > 0) && (n_up < 2100), 1'b1, "limit led flashes");
    press(1'b0, 1'b0, 1'b1, 8);
    check_bit(nozzle, 1'b1, "manual suction on");
    vec_ctrl_model_inst.send_sample(11'h2F8, 2);
    check_bit(nozzle, 1'b0, "manual regulation cut");
    vec_ctrl_model_inst.send_sample(11'h258, 2);
    check_bit(nozzle, 1'b1, "manual regulation resume");
    press(1'b0, 1'b1, 1'b0, 8);
    check_bit(nozzle, 1'b0, "manual suction off");
    @(negedge clk_sys_in);
    key_dn = 1'b1;
    cyc(10);
    check_bit(blow, 1'b1, "manual blow while held");
    check_bit(led_up & led_pt, 1'b1, "both leds steady");
    key_dn = 1'b0;
    cyc(8);
    vec_ctrl_model_inst.set_requests(1'b1, 1'b0);
    cyc(10);
    check_mode(VEC_ST_DISP, "request change leaves manual");
    check_bit(nozzle, 1'b1, "request acted on after exit");
    vec_ctrl_model_inst.set_requests(1'b0, 1'b0);
    cyc(8);
    $display("test manual done");
  endtask : test_manual
  // refused and accepted upper limit, maximum disables regulation
  task automatic test_limits();
    press(1'b1, 1'b0, 1'b0, 8);
    check_mode(VEC_ST_EDIT, "select opens menu");
    check_val(11'h003, "upper step shown");
    press(1'b0, 1'b1, 1'b0, 8);
    press(1'b0, 1'b1, 1'b0, 8);
    check_val(11'h001, "upper stepped down");
    press(1'b1, 1'b0, 1'b0, 8);
    press(1'b1, 1'b0, 1'b0, 8);
    check_val(11'h003, "upper not above part refused");
    repeat (3) press(1'b0, 1'b0, 1'b1, 8);
    check_val(11'h006, "upper at max step");
    press(1'b1, 1'b0, 1'b0, 8);
    check_mode(VEC_ST_DISP, "apply returns to display");
    vec_ctrl_model_inst.set_requests(1'b1, 1'b0);
    cyc(8);
    vec_ctrl_model_inst.send_sample(11'h3E8, 2);
    check_bit(nozzle, 1'b1, "no cut at max");
    vec_ctrl_model_inst.set_requests(1'b0, 1'b0);
    cyc(8);
    $display("test limits done");
  endtask : test_limits
  // blow time 20 ms chosen through the menu, run after suction ends
  task automatic test_timed_blow();
    press(1'b1, 1'b0, 1'b0, 8);
    press(1'b1, 1'b0, 1'b0, 8);
    press(1'b1, 1'b0, 1'b0, 8);
    check_val(11'h000, "blow time external");
    check_bit(led_up | led_pt, 1'b0, "only blow led may flash");
    press(1'b0, 1'b0, 1'b1, 8);
    press(1'b1, 1'b0, 1'b0, 8);
    vec_ctrl_model_inst.set_requests(1'b1, 1'b0);
    cyc(8);
    vec_ctrl_model_inst.set_requests(1'b0, 1'b0);
    cyc(10);
    check_bit(blow, 1'b1, "timed blow started");
    cyc(60);
    check_bit(blow, 1'b1, "timed blow still open");
    cyc(30);
    check_bit(blow, 1'b0, "timed blow over");
    $display("test timed blow done");
  endtask : test_timed_blow
  // down then select held together toggles the lock
  task automatic test_lock();
    @(negedge clk_sys_in);
    key_dn = 1'b1;
    cyc(4);
    key_sel = 1'b1;
    cyc(8);
    key_dn = 1'b0;
    key_sel = 1'b0;
    cyc(8);
    check_bit(locked, 1'b1, "chord locks");
    press(1'b1, 1'b0, 1'b0, 8);
    check_mode(VEC_ST_DISP, "select ignored while locked");
    @(negedge clk_sys_in);
    key_dn = 1'b1;
    cyc(4);
    key_sel = 1'b1;
    cyc(8);
    key_dn = 1'b0;
    key_sel = 1'b0;
    cyc(8);
    check_bit(locked, 1'b0, "chord unlocks");
    $display("test lock done");
  endtask : test_lock
  // the menu closes itself after the idle time
  task automatic test_idle();
    press(1'b1, 1'b0, 1'b0, 8);
    cyc(40);
    check_mode(VEC_ST_EDIT, "menu before idle time");
    cyc(60);
    check_mode(VEC_ST_DISP, "menu left after idle time");
    $display("test idle done");
  endtask : test_idle
  // reset, then the scenarios in order
  initial begin
    rstn_in = 1'b0;
    closed_idle = 1'b0;
    clk_en = 1'b1;
    key_sel = 1'b0;
    key_dn = 1'b0;
    key_up = 1'b0;
    cyc(16);
    rstn_in = 1'b1;
    test_reset();
    test_variants();
    test_regulation();
    test_ext_blow();
    test_manual();
    test_limits();
    test_timed_blow();
    test_lock();
    test_idle();
    give_verdict();
  end
endmodule : vec_ejector_ctrl_bench
